//--- design/blc_ctrl.sv
// Purpose: enable sequencing, dimming scale and protection states of a two-sink backlight boost
// Assumes: protection indications are comparator levels from outside this clock domain
// Notes: the one-wire interface is not built here; its enable result arrives as a level
`timescale 1ns/1ps
`default_nettype none
`include "blc_defs.svh"
// Summary of operation
// - pulse-width dimming is used whenever the one-wire interface is not up; the choice follows its level at all times, not only at startup.
// - with enable tied high, dimming high or toggling turns on and dimming low over 20 ms turns off.
// - with enable driven by a host, enable low over 2.5 ms or dimming low past its timeout turns off.
// - startup only begins once both enable and dimming are asserted.
// - a steady high dimming input gives full-scale current on both sinks.
// - each sink current is full scale times the measured dimming duty.
// - undervoltage holds shutdown and restart happens once the input recovers past hysteresis.
// - both the switch-node and the sink-node overvoltage indications are checked every cycle.
// - switch-node overvoltage latches off until power-on reset, undervoltage, or enable/dimming low past its timeout and then both high again.
// - switch-node overvoltage turns the power switch off and shuts the device down.
// - over-current turns the boost switch off until the next switching cycle starts.
// - over-temperature shuts down, resuming once the die has cooled 15 C below the trip.
module blc_ctrl #(
	parameter int DIM_LOW_CYCLES = `BLC_DIM_LOW_CYCLES,
	parameter int EN_LOW_CYCLES = `BLC_EN_LOW_CYCLES,
	parameter int CNT_W = 24
) (
	input wire logic clk, // core clock, 250 MHz
	input wire logic rst_b, // asynchronous reset, active low
	input wire logic enable_pin, // enable pin level
	input wire logic dim_pin, // dimming pin level
	input wire logic onewire_enabled, // one-wire interface came up at startup
	input wire logic cycle_start, // start of a switching cycle, from the oscillator
	input wire blc_pkg::blc_prot_t prot, // protection comparator levels
	output blc_pkg::blc_drive_t drive, // sink and switch drive
	output logic pwm_mode, // pulse-width dimming interface selected
	output blc_pkg::blc_state_t state // control state
);
	typedef struct packed {
		logic [1:0] en_s1, dim_s1;
		logic [5:0] prot_s1;
		logic [1:0] cyc_s1, ow_s1;
		logic en_s, dim_s, cyc_s, cyc_prev, ow_s;
		blc_pkg::blc_prot_t prot_s;
		logic [CNT_W-1:0] en_low_cnt;
		logic [CNT_W-1:0] dim_low_cnt;
		logic disabled_seen;
		logic oc_block;
		blc_pkg::blc_state_t st;
		blc_pkg::blc_drive_t drv;
		logic pwm_mode;
	} blc_ctrl_st_t;
	blc_ctrl_st_t s_q, s_d;
	logic rst_n_sync;
	logic [1:0] rst_sync_q, rst_sync_d;
	logic [`BLC_DUTY_W-1:0] duty;
	logic en_timeout, dim_timeout, want_on, ovp_any, cyc_rise;

	// reset stages kept apart from the state struct: they have their own reset
	assign rst_sync_d = {rst_sync_q[0], 1'b1};
	assign rst_n_sync = rst_sync_q[1];

	// duty measurement lives on its own; it only needs the synchronised level
	blc_duty_meter #(
		.DUTY_W(`BLC_DUTY_W),
		.PERIOD_W(`BLC_PERIOD_W)
	) u_meter (
		.clk(clk),
		.rst_n_sync(rst_n_sync),
		.dim(s_q.dim_s),
		.duty(duty)
	);

	// saturating low-time counter step
	function automatic logic [CNT_W-1:0] low_count(input logic lvl, input logic [CNT_W-1:0] c);
		if (lvl)
			low_count = '0;
		else if (&c)
			low_count = c;
		else
			low_count = c + 1'b1;
	endfunction

	// reset release; async assert to a constant, release through two stages
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rst_sync_q <= '0;
		else
			rst_sync_q <= rst_sync_d;
	end

	// all other state on the synchronised reset
	always_ff @(posedge clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			s_q.en_s1 <= '0;
			s_q.dim_s1 <= '0;
			s_q.prot_s1 <= '0;
			s_q.cyc_s1 <= '0;
			// assume one-wire up until the chain says otherwise, so no start slips in early
			s_q.ow_s1 <= '1;
			s_q.en_s <= 1'b0;
			s_q.dim_s <= 1'b0;
			s_q.cyc_s <= 1'b0;
			s_q.cyc_prev <= 1'b0;
			s_q.ow_s <= 1'b1;
			s_q.prot_s <= '0;
			s_q.en_low_cnt <= '0;
			s_q.dim_low_cnt <= '0;
			s_q.disabled_seen <= 1'b0;
			s_q.oc_block <= 1'b0;
			s_q.st <= blc_pkg::BLC_OFF;
			s_q.drv <= '0;
			s_q.pwm_mode <= 1'b0;
		end
		else
		begin
			s_q.en_s1 <= s_d.en_s1;
			s_q.dim_s1 <= s_d.dim_s1;
			s_q.prot_s1 <= s_d.prot_s1;
			s_q.cyc_s1 <= s_d.cyc_s1;
			s_q.ow_s1 <= s_d.ow_s1;
			s_q.en_s <= s_d.en_s;
			s_q.dim_s <= s_d.dim_s;
			s_q.cyc_s <= s_d.cyc_s;
			s_q.cyc_prev <= s_d.cyc_prev;
			s_q.ow_s <= s_d.ow_s;
			s_q.prot_s <= s_d.prot_s;
			s_q.en_low_cnt <= s_d.en_low_cnt;
			s_q.dim_low_cnt <= s_d.dim_low_cnt;
			s_q.disabled_seen <= s_d.disabled_seen;
			s_q.oc_block <= s_d.oc_block;
			s_q.st <= s_d.st;
			s_q.drv <= s_d.drv;
			s_q.pwm_mode <= s_d.pwm_mode;
		end
	end

	// timeouts count from the synchronised levels; a tied-high enable never times out
	assign en_timeout = (s_q.en_low_cnt >= CNT_W'(EN_LOW_CYCLES));
	assign dim_timeout = (s_q.dim_low_cnt >= CNT_W'(DIM_LOW_CYCLES));
	assign want_on = s_q.en_s && s_q.dim_s;
	assign ovp_any = s_q.prot_s.switch_ovp || s_q.prot_s.sink_ovp;
	assign cyc_rise = s_q.cyc_s && !s_q.cyc_prev;

	always_comb
	begin
		s_d = s_q;
		// three-stage synchronisers on the pins, two-stage on prot; each stage feeds only the next
		s_d.en_s1 = {s_q.en_s1[0], enable_pin};
		s_d.dim_s1 = {s_q.dim_s1[0], dim_pin};
		s_d.prot_s1 = prot;
		s_d.cyc_s1 = {s_q.cyc_s1[0], cycle_start};
		s_d.ow_s1 = {s_q.ow_s1[0], onewire_enabled};
		s_d.en_s = s_q.en_s1[1];
		s_d.dim_s = s_q.dim_s1[1];
		s_d.prot_s = s_q.prot_s1;
		s_d.cyc_s = s_q.cyc_s1[1];
		s_d.ow_s = s_q.ow_s1[1];
		s_d.cyc_prev = s_q.cyc_s;
		s_d.en_low_cnt = low_count(s_q.en_s, s_q.en_low_cnt);
		s_d.dim_low_cnt = low_count(s_q.dim_s, s_q.dim_low_cnt);
		// interface choice falls back to pulse-width whenever one-wire is not up
		s_d.pwm_mode = !s_q.ow_s;
		// over-current blocks the switch for the rest of this cycle only
		if (cyc_rise)
			s_d.oc_block = 1'b0;
		if (s_q.prot_s.over_current)
			s_d.oc_block = 1'b1;
		unique case (s_q.st)
			blc_pkg::BLC_OFF:
			begin
				if (s_q.prot_s.undervoltage)
					s_d.st = blc_pkg::BLC_UVLO;
				else if (s_q.prot_s.over_temp)
					s_d.st = blc_pkg::BLC_THERM;
				else if (want_on && s_q.pwm_mode)
					s_d.st = blc_pkg::BLC_RUN;
			end
			blc_pkg::BLC_RUN:
			begin
				if (s_q.prot_s.undervoltage)
					s_d.st = blc_pkg::BLC_UVLO;
				else if (s_q.prot_s.switch_ovp)
				begin
					s_d.st = blc_pkg::BLC_OVP_LATCH;
					s_d.disabled_seen = 1'b0;
				end
				else if (s_q.prot_s.over_temp)
					s_d.st = blc_pkg::BLC_THERM;
				else if (en_timeout || dim_timeout || !s_q.pwm_mode)
					s_d.st = blc_pkg::BLC_OFF;
			end
			blc_pkg::BLC_OVP_LATCH:
			begin
				// leave on undervoltage, or after a completed disable then a new enable
				if (en_timeout || dim_timeout)
					s_d.disabled_seen = 1'b1;
				if (s_q.prot_s.undervoltage)
					s_d.st = blc_pkg::BLC_UVLO;
				else if (s_q.disabled_seen && want_on)
					s_d.st = blc_pkg::BLC_OFF;
			end
			blc_pkg::BLC_UVLO:
			begin
				// the comparator carries the hysteresis; release means input recovered
				if (!s_q.prot_s.undervoltage)
					s_d.st = blc_pkg::BLC_OFF;
			end
			blc_pkg::BLC_THERM:
			begin
				if (s_q.prot_s.undervoltage)
					s_d.st = blc_pkg::BLC_UVLO;
				else if (s_q.prot_s.temp_recovered && !s_q.prot_s.over_temp)
					s_d.st = blc_pkg::BLC_OFF;
			end
		endcase
		// drive: sinks scaled by duty; switch off on any overvoltage or current block
		s_d.drv.sink_enable = (s_d.st == blc_pkg::BLC_RUN);
		s_d.drv.sink_level = (s_d.st == blc_pkg::BLC_RUN) ? duty : '0;
		s_d.drv.boost_switch_on = (s_d.st == blc_pkg::BLC_RUN) && !ovp_any
			&& !s_d.oc_block;
	end

	assign drive = s_q.drv;
	assign pwm_mode = s_q.pwm_mode;
	assign state = s_q.st;
endmodule
`default_nettype wire

//--- design/blc_defs.svh
// Purpose: timing and sizing constants for the backlight enable/protect control
// Assumes: 250 MHz core clock (4 ns period)
// Notes: times are kept in their own unit; cycle counts are derived from them
`ifndef BLC_DEFS_SVH
`define BLC_DEFS_SVH
`define BLC_CLK_PERIOD_PS 4000
`define BLC_DIM_LOW_TIMEOUT_US 20000
`define BLC_EN_LOW_TIMEOUT_US 2500
// worked in ns so the intermediate product stays inside 32-bit integer range
`define BLC_DIM_LOW_CYCLES ((`BLC_DIM_LOW_TIMEOUT_US * 1000) / (`BLC_CLK_PERIOD_PS / 1000))
`define BLC_EN_LOW_CYCLES ((`BLC_EN_LOW_TIMEOUT_US * 1000) / (`BLC_CLK_PERIOD_PS / 1000))
`define BLC_DUTY_W 9
`define BLC_PERIOD_W 24
`define BLC_ISCALE_W 8
`define BLC_ISCALE_RST 8'hff
`endif

//--- design/blc_pkg.sv
// Purpose: shared types of the backlight enable/protect control
// Assumes: constants come from blc_defs.svh
// Notes: types only
`default_nettype none
`include "blc_defs.svh"
package blc_pkg;
	typedef enum logic [4:0] {
		BLC_OFF = 5'h01,
		BLC_RUN = 5'h02,
		BLC_OVP_LATCH = 5'h04,
		BLC_UVLO = 5'h08,
		BLC_THERM = 5'h10
	} blc_state_t;
	typedef struct packed {
		logic undervoltage;
		logic switch_ovp;
		logic sink_ovp;
		logic over_current;
		logic over_temp;
		logic temp_recovered;
	} blc_prot_t;
	typedef struct packed {
		logic sink_enable;
		logic boost_switch_on;
		logic [`BLC_DUTY_W-1:0] sink_level;
	} blc_drive_t;
endpackage
`default_nettype wire

//--- design/blc_duty_meter.sv
// Purpose: measures duty of the dimming input as a fraction of 2**DUTY_W
// Assumes: dim input already synchronised to clk
// Notes: a steady high input reads full scale once it outlasts the last period; steady low reads zero once the period counter saturates
`timescale 1ns/1ps
`default_nettype none
`include "blc_defs.svh"
module blc_duty_meter #(
	parameter int DUTY_W = `BLC_DUTY_W,
	parameter int PERIOD_W = `BLC_PERIOD_W
) (
	input wire logic clk, // core clock
	input wire logic rst_n_sync, // synchronised reset, active low
	input wire logic dim, // synchronised dimming level
	output logic [DUTY_W-1:0] duty // latest duty fraction
);
	typedef struct packed {
		logic dim_prev;
		logic [PERIOD_W-1:0] total;
		logic [PERIOD_W-1:0] high;
		logic [PERIOD_W-1:0] last;
		logic [DUTY_W-1:0] duty;
	} blc_meter_t;
	blc_meter_t s_q, s_d;
	logic [PERIOD_W+DUTY_W-1:0] scaled;
	logic close;
	// period closes on a rising edge, or when the counter saturates (steady level)
	always_comb
	begin
		s_d = s_q;
		scaled = {s_q.high, {DUTY_W{1'b0}}} / {{DUTY_W{1'b0}}, s_q.total};
		close = (dim && !s_q.dim_prev) || (&s_q.total);
		s_d.dim_prev = dim;
		if (close)
		begin
			if (s_q.total == '0)
				s_d.duty = dim ? '1 : '0;
			else if (s_q.high == s_q.total)
				s_d.duty = '1;
			else
				s_d.duty = scaled[DUTY_W-1:0];
			s_d.last = s_q.total;
			// the closing sample opens the next period, so no cycle is lost
			s_d.total = {{(PERIOD_W-1){1'b0}}, 1'b1};
			s_d.high = {{(PERIOD_W-1){1'b0}}, dim};
		end
		else
		begin
			s_d.total = s_q.total + 1'b1;
			s_d.high = s_q.high + {{(PERIOD_W-1){1'b0}}, dim};
			// high for a whole last period with no fall: full scale now, not at saturation
			if (dim && (s_q.high == s_q.total) && (s_q.total >= s_q.last))
				s_d.duty = '1;
		end
	end
	always_ff @(posedge clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign duty = s_q.duty;
endmodule
`default_nettype wire

//--- sim/blc_ctrl_sva.sv
// Purpose: port assertions for the backlight enable/protect control
// Assumes: one clock, rst_b active low
// Notes: pin delays allow for the three-flop sync plus one register
`timescale 1ns/1ps
`default_nettype none
module blc_ctrl_sva #(
	parameter int DIM_LOW_CYCLES = 50,
	parameter int EN_LOW_CYCLES = 20
) (
	input wire logic clk, // core clock
	input wire logic rst_b, // reset, active low
	input wire logic enable_pin, // enable pin
	input wire logic dim_pin, // dimming pin
	input wire logic onewire_enabled, // one-wire came up
	input wire logic cycle_start, // switching cycle start
	input wire blc_pkg::blc_prot_t prot, // protection levels
	input wire blc_pkg::blc_drive_t drive, // sink and switch drive
	input wire logic pwm_mode, // pulse-width mode
	input wire blc_pkg::blc_state_t state // control state
);
	logic [23:0] dlo_q;
	logic [23:0] elo_q;
	logic run;
	logic latch;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	assign run = state == blc_pkg::BLC_RUN;
	assign latch = state == blc_pkg::BLC_OVP_LATCH;
	// raw low-time counters; saturating so a long idle cannot wrap
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dlo_q <= 24'h000000;
			elo_q <= 24'h000000;
		end
		else
		begin
			dlo_q <= dim_pin ? 24'h000000 : dlo_q + 24'(dlo_q != 24'hffffff);
			elo_q <= enable_pin ? 24'h000000 : elo_q + 24'(elo_q != 24'hffffff);
		end
	end
	a_pwm_select: assert property ($stable(onewire_enabled) [*8] |-> pwm_mode == !onewire_enabled)
		else $error("pwm mode wrong");
	a_start_refused: assert property ((!run && (onewire_enabled || !enable_pin || !dim_pin)) [*6] |=> !run)
		else $error("started without both pins");
	a_dim_timeout: assert property (dlo_q > DIM_LOW_CYCLES + 6 |-> !run)
		else $error("dimming low timeout missed");
	a_en_timeout: assert property (elo_q > EN_LOW_CYCLES + 6 |-> !run)
		else $error("enable low timeout missed");
	a_ovp_latch: assert property ((run && prot.switch_ovp && !prot.undervoltage && !prot.over_temp) [*2]
		|-> ##[1:5] latch) else $error("switch overvoltage not latched");
	a_ovp_off: assert property (latch |-> !drive.boost_switch_on && !drive.sink_enable)
		else $error("drive on while latched");
	a_latch_holds: assert property ((latch && enable_pin && dim_pin && !prot.undervoltage) [*8] |=> latch)
		else $error("latch left without timeout");
	a_oc_cut: assert property ((!cycle_start) [*4] ##0 (prot.over_current && !cycle_start)
		##1 (!cycle_start) [*5] |-> !drive.boost_switch_on) else $error("switch on in over-current");
	a_sink_ovp: assert property (prot.sink_ovp [*5] |-> !drive.boost_switch_on)
		else $error("switch on in sink overvoltage");
	a_uvlo_off: assert property (prot.undervoltage [*5] |-> !run && !drive.sink_enable)
		else $error("running in undervoltage");
endmodule
bind blc_ctrl blc_ctrl_sva #(.DIM_LOW_CYCLES(DIM_LOW_CYCLES), .EN_LOW_CYCLES(EN_LOW_CYCLES)) sva_u (
	.clk(clk), .rst_b(rst_b), .enable_pin(enable_pin), .dim_pin(dim_pin),
	.onewire_enabled(onewire_enabled), .cycle_start(cycle_start), .prot(prot),
	.drive(drive), .pwm_mode(pwm_mode), .state(state));
`default_nettype wire

//--- sim/blc_host.sv
// Purpose: host model driving the enable and dimming pins
// Assumes: commands change at clock edges
// Notes: dimming is high for hi cycles of every per cycles
`timescale 1ns/1ps
`default_nettype none
module blc_host (
	input wire logic clk, // core clock
	input wire logic en_cmd, // wanted enable level
	input wire logic [7:0] per, // dimming period in cycles
	input wire logic [7:0] hi, // high cycles per period
	output logic enable_pin = 1'b0, // enable pin drive
	output logic dim_pin = 1'b0 // dimming pin drive
);
	logic [7:0] cnt_q = 8'h00;
	// push-pull host outputs, so the pins always carry a level
	always @(posedge clk)
	begin
		cnt_q <= (cnt_q + 8'h01 >= per) ? 8'h00 : cnt_q + 8'h01;
		enable_pin <= en_cmd;
		dim_pin <= cnt_q < hi;
	end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Purpose: self-checking bench for the backlight control
// Assumes: timeouts shortened to 50 and 20 cycles
// Notes: start refusal first, then duty rows, then timeouts and protection cases
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk;
	logic rst_b;
	logic en_cmd;
	logic onewire_enabled;
	logic cycle_start;
	logic enable_pin;
	logic dim_pin;
	logic pwm_mode;
	logic [7:0] per;
	logic [7:0] hi;
	blc_pkg::blc_prot_t prot;
	blc_pkg::blc_drive_t drive;
	blc_pkg::blc_state_t state;
	int n_mismatch;
	int cmp_count;
	int i;
	// period, high cycles, expected sink level (high*512/period)
	logic [8:0] rows [5][3] = '{'{9'h010, 9'h008, 9'h100}, '{9'h010, 9'h004, 9'h080},
		'{9'h020, 9'h001, 9'h010}, '{9'h040, 9'h03f, 9'h1f8}, '{9'h008, 9'h007, 9'h1c0}};
	blc_host host_u (.clk(clk), .en_cmd(en_cmd), .per(per), .hi(hi),
		.enable_pin(enable_pin), .dim_pin(dim_pin));
	blc_ctrl #(.DIM_LOW_CYCLES(50), .EN_LOW_CYCLES(20)) dut_u (.clk(clk), .rst_b(rst_b),
		.enable_pin(enable_pin), .dim_pin(dim_pin), .onewire_enabled(onewire_enabled),
		.cycle_start(cycle_start), .prot(prot), .drive(drive), .pwm_mode(pwm_mode), .state(state));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// sample 1 ns after the edge so its updates have landed
	task automatic cks(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
		cmp_count++;
		if (exp !== got)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// bounded wait for a state; running out ends the run
	task automatic wst(input blc_pkg::blc_state_t s);
		int k;
		#1;
		for (k = 0; k < 40 && state !== s; k++)
			cks(1);
		chk("state", 11'(s), 11'(state));
		if (k == 40 && state !== s)
			results();
	endtask
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		rst_b = 1'b0;
		en_cmd = 1'b1;
		onewire_enabled = 1'b1;
		cycle_start = 1'b0;
		prot = '0;
		per = 8'h10;
		hi = 8'hff;
		n_mismatch = 0;
		cmp_count = 0;
		cyc(20);
		rst_b <= 1'b1;
		cks(30);
		chk("state", 11'(blc_pkg::BLC_OFF), 11'(state));
		cyc(1);
		onewire_enabled <= 1'b0;
		hi <= 8'h00;
		cks(30);
		chk("state", 11'(blc_pkg::BLC_OFF), 11'(state));
		chk("pwm_mode", 11'h001, 11'(pwm_mode));
		cyc(1);
		hi <= 8'hff;
		wst(blc_pkg::BLC_RUN);
		for (i = 0; i < 5; i++)
		begin
			cyc(1);
			per <= rows[i][0][7:0];
			hi <= rows[i][1][7:0];
			cks(200);
			chk("sink_level", 11'(rows[i][2]), 11'(drive.sink_level));
		end
		// steady high after a pulse train must read full scale
		cyc(1);
		hi <= 8'hff;
		cks(40);
		chk("sink_level", 11'h1ff, 11'(drive.sink_level));
		// dimming low just short of, then past, its timeout
		cyc(1);
		hi <= 8'h00;
		cks(40);
		wst(blc_pkg::BLC_RUN);
		cyc(30);
		wst(blc_pkg::BLC_OFF);
		cyc(1);
		hi <= 8'hff;
		wst(blc_pkg::BLC_RUN);
		cyc(1);
		en_cmd <= 1'b0;
		cks(12);
		wst(blc_pkg::BLC_RUN);
		cyc(30);
		wst(blc_pkg::BLC_OFF);
		cyc(1);
		en_cmd <= 1'b1;
		wst(blc_pkg::BLC_RUN);
		// one-cycle over-current, then a new switching cycle
		cyc(1);
		prot.over_current <= 1'b1;
		cyc(1);
		prot.over_current <= 1'b0;
		cks(10);
		chk("boost", 11'h000, 11'(drive.boost_switch_on));
		cyc(1);
		cycle_start <= 1'b1;
		prot.sink_ovp <= 1'b1;
		cyc(2);
		cycle_start <= 1'b0;
		cks(8);
		chk("boost", 11'h000, 11'(drive.boost_switch_on));
		cyc(1);
		prot.sink_ovp <= 1'b0;
		cycle_start <= 1'b1;
		cyc(2);
		cycle_start <= 1'b0;
		cks(8);
		chk("boost", 11'h001, 11'(drive.boost_switch_on));
		// latch cleared by dimming timeout, then by enable timeout
		for (i = 0; i < 2; i++)
		begin
			cyc(1);
			prot.switch_ovp <= 1'b1;
			wst(blc_pkg::BLC_OVP_LATCH);
			chk("drive", 11'h000, 11'({drive.sink_enable, drive.boost_switch_on}));
			cyc(1);
			prot.switch_ovp <= 1'b0;
			hi <= 8'h00;
			cyc(8);
			hi <= 8'hff;
			cks(20);
			chk("state", 11'(blc_pkg::BLC_OVP_LATCH), 11'(state));
			cyc(1);
			en_cmd <= ~i[0];
			hi <= {8{i[0]}};
			cyc(70);
			en_cmd <= 1'b1;
			hi <= 8'hff;
			wst(blc_pkg::BLC_RUN);
		end
		cyc(1);
		prot.undervoltage <= 1'b1;
		wst(blc_pkg::BLC_UVLO);
		cyc(5);
		prot.undervoltage <= 1'b0;
		wst(blc_pkg::BLC_RUN);
		cyc(1);
		prot.over_temp <= 1'b1;
		wst(blc_pkg::BLC_THERM);
		cyc(5);
		prot.over_temp <= 1'b0;
		cks(20);
		chk("state", 11'(blc_pkg::BLC_THERM), 11'(state));
		cyc(1);
		prot.temp_recovered <= 1'b1;
		wst(blc_pkg::BLC_RUN);
		// one-wire coming up while running drops pulse-width mode
		cyc(1);
		onewire_enabled <= 1'b1;
		wst(blc_pkg::BLC_OFF);
		chk("pwm_mode", 11'h000, 11'(pwm_mode));
		cyc(1);
		onewire_enabled <= 1'b0;
		wst(blc_pkg::BLC_RUN);
		cyc(1);
		rst_b <= 1'b0;
		cks(2);
		chk("drive", 11'h000, 11'(drive));
		cyc(1);
		rst_b <= 1'b1;
		wst(blc_pkg::BLC_RUN);
		results();
	end
endmodule
`default_nettype wire
